// >>> dv/flow_pulse_pair_decoder_tb.sv
// self-checking bench for the flow pulse pair decoder
`timescale 1ns/100ps
module flow_pulse_pair_decoder_tb;
	import fppd_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        pin_odd, pin_even, dp_strobe, er;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, dp_odd, dp_even, rd;
	int          mismatches, cmp_count, f, r, n, m, k;
	logic [1:0]  q [4] = '{2'b00, 2'b01, 2'b11, 2'b10};

	always #5 pclk = ~pclk;

	fppd_top #(.SDIV_DEFAULT(16'h0001)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_odd(pin_odd), .pin_even(pin_even),
		.dp_strobe(dp_strobe), .dp_odd(dp_odd), .dp_even(dp_even));
	fppd_meter meter (.pclk(pclk), .pin_odd(pin_odd), .pin_even(pin_even));

	task automatic wrap_up;
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			mismatches++;
			wrap_up();
		end
	endtask

	// close a log period and optionally compare the datapoints
	task automatic logp(input logic [31:0] eo, input logic [31:0] ee, input logic c);
		int t;
		apb(1'b1, A_LOG, 32'h1);
		t = 0;
		do begin
			@(posedge pclk);
			t++;
		end while (dp_strobe !== 1'b1 && t < 20);
		if (dp_strobe !== 1'b1) begin
			mismatches++;
			wrap_up();
		end
		if (c) begin
			chk("dp_odd", eo, dp_odd);
			chk("dp_even", ee, dp_even);
		end
	endtask

	task automatic cfg(input logic [31:0] v);
		apb(1'b1, A_CTRL, v);
		logp(32'h0, 32'h0, 1'b0);
		f = 0;
		r = 0;
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		mismatches = 0;
		cmp_count = 0;
		n = $urandom(45);
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, A_SDIV, 32'h0);
		chk("sdiv", 32'h1, rd);
		chk("err_ok", 32'h0, {31'h0, er});
		apb(1'b1, A_SDIV, 32'h0);
		apb(1'b0, A_SDIV, 32'h0);
		chk("sdiv_zero", 32'h1, rd);
		n = $urandom_range(1, 5);
		apb(1'b1, A_SDIV, n);
		apb(1'b0, A_SDIV, 32'h0);
		chk("sdiv_set", n, rd);
		// uni-directional on both pins
		cfg(32'h21);
		n = $urandom_range(1, 6);
		m = $urandom_range(1, 6);
		for (k = 0; k < n; k++) begin
			meter.drive(1'b1, 1'b0);
			meter.drive(1'b0, 1'b0);
		end
		for (k = 0; k < m; k++) begin
			meter.drive(1'b0, 1'b1);
			meter.drive(1'b0, 1'b0);
		end
		meter.drive(1'b1, 1'b1);
		apb(1'b0, A_STAT, 32'h0);
		chk("stat_pins", 32'h3, rd & 32'h3);
		meter.drive(1'b0, 1'b0);
		logp(n + 1, m + 1, 1'b1);
		apb(1'b0, A_TOT_FWD, 32'h0);
		chk("tot_fwd", n + 1, rd);
		apb(1'b0, A_TOT_REV, 32'h0);
		chk("tot_rev", m + 1, rd);
		// even pin alone, odd pin left free
		cfg(32'h20);
		for (k = 0; k < n; k++) begin
			meter.drive(1'b1, 1'b1);
			meter.drive(1'b0, 1'b0);
		end
		logp(32'h0, n, 1'b1);
		apb(1'b0, A_STAT, 32'h0);
		chk("unclaimed", 32'h0, rd & 32'h8);
		// pulse plus direction, net then independent storage
		for (int s = 0; s < 2; s++) begin
			cfg(32'h22 | (s << 4));
			n = $urandom_range(2, 8);
			for (k = 0; k < n; k++) begin
				m = (k < 2) ? 1 - k : $urandom_range(0, 1);
				meter.drive(1'b0, m[0]);
				meter.drive(1'b1, m[0]);
				meter.drive(1'b0, 1'b0);
				if (m == 1) r++;
				else f++;
			end
			apb(1'b0, A_STAT, 32'h0);
			chk("claimed", 32'h8, rd & 32'h8);
			chk("dir", m << 2, rd & 32'h4);
			logp(s ? f : f - r, s ? r : 0, 1'b1);
		end
		// separate forward and reverse lines
		cfg(32'h6);
		n = $urandom_range(1, 6);
		m = $urandom_range(1, 6);
		for (k = 0; k < n; k++) begin
			meter.drive(1'b1, 1'b0);
			meter.drive(1'b0, 1'b0);
		end
		for (k = 0; k < m; k++) begin
			meter.drive(1'b0, 1'b1);
			meter.drive(1'b0, 1'b0);
		end
		logp(n - m, 32'h0, 1'b1);
		// quadrature: forward cycles, reverse cycles, then illegal jumps
		cfg(32'hA);
		n = $urandom_range(1, 3);
		m = $urandom_range(1, 3);
		for (k = 1; k <= 4 * n; k++) meter.drive(q[k % 4][1], q[k % 4][0]);
		for (k = 4 * m - 1; k >= 0; k--) meter.drive(q[k % 4][1], q[k % 4][0]);
		meter.drive(1'b1, 1'b1);
		meter.drive(1'b0, 1'b0);
		logp(4 * (n - m), 32'h0, 1'b1);
		// unmapped and unaligned accesses
		apb(1'b0, 8'h20, 32'h0);
		chk("err_unmapped", 32'h1, {31'h0, er});
		chk("rd_unmapped", 32'h0, rd);
		apb(1'b1, 8'h02, 32'h5);
		chk("err_unaligned", 32'h1, {31'h0, er});
		wrap_up();
	end
endmodule

// >>> dv/fppd_meter.sv
// flow meter model driving the decoder's pulse pin pair
`timescale 1ns/100ps
module fppd_meter (
	input  wire logic pclk,
	output logic      pin_odd,
	output logic      pin_even
);
	initial begin
		pin_odd = 1'b0;
		pin_even = 1'b0;
	end
	// each level stays well beyond one sample period so no edge is missed
	task automatic drive(input logic o, input logic e);
		@(posedge pclk);
		pin_odd <= o;
		pin_even <= e;
		repeat (8) @(posedge pclk);
	endtask
endmodule

// >>> logic/fppd_pkg.sv
// constants and types for the flow pulse pair decoder
package fppd_pkg;
	localparam int          DW          = 32;
	localparam logic [7:0]  A_CTRL      = 8'h00;
	localparam logic [7:0]  A_SDIV      = 8'h04;
	localparam logic [7:0]  A_LOG       = 8'h08;
	localparam logic [7:0]  A_STAT      = 8'h0C;
	localparam logic [7:0]  A_TOT_FWD   = 8'h10;
	localparam logic [7:0]  A_TOT_REV   = 8'h14;
	localparam logic [7:0]  A_DP_ODD    = 8'h18;
	localparam logic [7:0]  A_DP_EVEN   = 8'h1C;
	// control field positions
	localparam int          C_MODE_LO   = 0;
	localparam int          C_PCFG_LO   = 2;
	localparam int          C_STORE     = 4;
	localparam int          C_EVEN_UNI  = 5;
	localparam int          C_WIDTH     = 6;
	localparam logic [5:0]  CTRL_RST    = 6'h00;
	// status field positions
	localparam int          S_ODD_PIN   = 0;
	localparam int          S_EVEN_PIN  = 1;
	localparam int          S_DIR_REV   = 2;
	localparam int          S_CLAIMED   = 3;
	localparam int          SDIV_W      = 16;
	localparam logic [15:0] SDIV_RST    = 16'h0063;
	typedef enum logic [1:0] {
		FPPD_OFF   = 2'h0,
		FPPD_UNI   = 2'h1,
		FPPD_BIDIR = 2'h2
	} fppd_mode_t;
	typedef enum logic [1:0] {
		FPPD_PULSE_DIR = 2'h0,
		FPPD_FWD_REV   = 2'h1,
		FPPD_QUAD      = 2'h2
	} fppd_pcfg_t;
endpackage

// >>> logic/fppd_top.sv
// flow pulse pair decoder with apb register access
`timescale 1ns/100ps
module fppd_top
	import fppd_pkg::*;
#(
	parameter logic [15:0] SDIV_DEFAULT = fppd_pkg::SDIV_RST
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                pin_odd,
	input  wire logic                pin_even,
	output logic                     dp_strobe,
	output logic      [31:0]         dp_odd,
	output logic      [31:0]         dp_even
);
	import fppd_pkg::*;

	logic [1:0]            sync1_q;
	logic [1:0]            sync2_q;
	logic [1:0]            smp_q;
	logic [C_WIDTH-1:0]    ctrl_q;
	logic [SDIV_W-1:0]     sdiv_q;
	logic [SDIV_W-1:0]     scnt_q;
	logic                  se_q;
	logic                  dir_q;
	logic                  pready_q;
	logic                  pslverr_q;
	logic [31:0]           prdata_q;
	logic [31:0]           tot_f_q;
	logic [31:0]           tot_r_q;
	logic [31:0]           per_f_q;
	logic [31:0]           per_r_q;
	logic [31:0]           dp_odd_q;
	logic [31:0]           dp_even_q;
	logic                  dp_strobe_q;
	logic                  log_q;
	logic                  wr_en;
	logic                  map_ok;
	logic [31:0]           rd_d;
	fppd_mode_t            mode;
	fppd_pcfg_t            pcfg;
	logic                  claimed;
	logic                  even_uni;
	logic                  indep;
	logic                  rise_o;
	logic                  rise_e;
	logic                  q_fwd;
	logic                  q_rev;
	logic                  inc_f;
	logic                  inc_r;

	assign prdata    = prdata_q;
	assign pready    = pready_q;
	assign pslverr   = pslverr_q;
	assign dp_strobe = dp_strobe_q;
	assign dp_odd    = dp_odd_q;
	assign dp_even   = dp_even_q;

	// configuration decode
	assign mode     = fppd_mode_t'(ctrl_q[C_MODE_LO +: 2]);
	assign pcfg     = fppd_pcfg_t'(ctrl_q[C_PCFG_LO +: 2]);
	assign claimed  = (mode == FPPD_BIDIR);
	assign even_uni = ctrl_q[C_EVEN_UNI] && !claimed;
	assign indep    = claimed && (pcfg == FPPD_PULSE_DIR) && ctrl_q[C_STORE];

	// pin synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 2'h0;
			sync2_q <= 2'h0;
		end else begin
			sync1_q <= {pin_even, pin_odd};
			sync2_q <= sync1_q;
		end
	end

	// dedicated sample rate divider
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scnt_q <= 16'h0000;
			se_q   <= 1'b0;
		end else if (scnt_q >= sdiv_q) begin
			scnt_q <= 16'h0000;
			se_q   <= 1'b1;
		end else begin
			scnt_q <= scnt_q + 16'h0001;
			se_q   <= 1'b0;
		end
	end

	// bit 0 odd pin, bit 1 even pin; 1 = closed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			smp_q <= 2'h0;
		end else if (se_q) begin
			smp_q <= sync2_q;
		end
	end

	assign rise_o = se_q && sync2_q[0] && !smp_q[0];
	assign rise_e = se_q && sync2_q[1] && !smp_q[1];

	// quadrature pair read as {odd, even}
	always_comb begin
		q_fwd = 1'b0;
		q_rev = 1'b0;
		if (se_q) begin
			case ({smp_q[0], smp_q[1], sync2_q[0], sync2_q[1]})
				4'b0001, 4'b0111, 4'b1110, 4'b1000: q_fwd = 1'b1;
				4'b0010, 4'b1011, 4'b1101, 4'b0100: q_rev = 1'b1;
				default: begin
					q_fwd = 1'b0;
					q_rev = 1'b0;
				end
			endcase
		end
	end

	// forward / reverse event selection
	always_comb begin
		inc_f = 1'b0;
		inc_r = 1'b0;
		case (mode)
			FPPD_UNI: begin
				inc_f = rise_o;
				inc_r = even_uni && rise_e;
			end
			FPPD_BIDIR: begin
				case (pcfg)
					FPPD_PULSE_DIR: begin
						inc_f = rise_o && !sync2_q[1];
						inc_r = rise_o && sync2_q[1];
					end
					FPPD_FWD_REV: begin
						inc_f = rise_o;
						inc_r = rise_e;
					end
					FPPD_QUAD: begin
						inc_f = q_fwd;
						inc_r = q_rev;
					end
					default: begin
						inc_f = 1'b0;
						inc_r = 1'b0;
					end
				endcase
			end
			default: begin
				inc_f = even_uni && 1'b0;
				inc_r = even_uni && rise_e;
			end
		endcase
	end

	// accumulated totals and last detected direction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tot_f_q <= 32'h00000000;
			tot_r_q <= 32'h00000000;
			dir_q   <= 1'b0;
		end else begin
			tot_f_q <= tot_f_q + {31'h0, inc_f};
			tot_r_q <= tot_r_q + {31'h0, inc_r};
			if (claimed && pcfg != FPPD_FWD_REV && (inc_f || inc_r)) begin
				dir_q <= inc_r;
			end
		end
	end

	// period counters restart at the boundary, keeping a same-cycle pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			per_f_q <= 32'h00000000;
			per_r_q <= 32'h00000000;
		end else if (log_q) begin
			per_f_q <= {31'h0, inc_f};
			per_r_q <= {31'h0, inc_r};
		end else begin
			per_f_q <= per_f_q + {31'h0, inc_f};
			per_r_q <= per_r_q + {31'h0, inc_r};
		end
	end

	// datapoint capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dp_odd_q    <= 32'h00000000;
			dp_even_q   <= 32'h00000000;
			dp_strobe_q <= 1'b0;
		end else begin
			dp_strobe_q <= log_q;
			if (log_q) begin
				if (claimed && !indep) begin
					dp_odd_q  <= per_f_q - per_r_q;
					dp_even_q <= 32'h00000000;
				end else begin
					dp_odd_q  <= per_f_q;
					dp_even_q <= per_r_q;
				end
			end
		end
	end

	// apb slave: one wait state, write and read data at the pready edge
	assign wr_en  = psel && penable && pwrite && pready_q;
	assign map_ok = (paddr[1:0] == 2'h0) && (paddr <= A_DP_EVEN);

	always_comb begin
		rd_d = 32'h00000000;
		case (paddr)
			A_CTRL:    rd_d = {26'h0, ctrl_q};
			A_SDIV:    rd_d = {16'h0000, sdiv_q};
			A_STAT:    rd_d = {28'h0000000, claimed, dir_q, sync2_q[1], sync2_q[0]};
			A_TOT_FWD: rd_d = tot_f_q;
			A_TOT_REV: rd_d = tot_r_q;
			A_DP_ODD:  rd_d = dp_odd_q;
			A_DP_EVEN: rd_d = dp_even_q;
			default:   rd_d = 32'h00000000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h00000000;
		end else begin
			pready_q  <= psel && penable && !pready_q;
			pslverr_q <= psel && penable && !pready_q && !map_ok;
			if (psel && penable && !pready_q && !pwrite) begin
				prdata_q <= rd_d;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RST;
			sdiv_q <= 16'h0000;
			log_q  <= 1'b0;
		end else begin
			log_q <= wr_en && map_ok && paddr == A_LOG && pwdata[0];
			if (sdiv_q == 16'h0000) begin
				sdiv_q <= SDIV_DEFAULT;
			end
			if (wr_en && map_ok && paddr == A_CTRL) begin
				ctrl_q <= pwdata[C_WIDTH-1:0];
			end
			if (wr_en && map_ok && paddr == A_SDIV && pwdata[15:0] != 16'h0000) begin
				sdiv_q <= pwdata[15:0];
			end
		end
	end

	sequence s_uni_rise;
		mode == FPPD_UNI && rise_o;
	endsequence
	sequence s_boundary;
		log_q && !inc_f;
	endsequence

	AST_UNI_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
		s_uni_rise |=> tot_f_q == $past(tot_f_q) + 32'h00000001)
		else $error("uni edge not counted");
	AST_PD_REV: assert property (@(posedge pclk) disable iff (!presetn)
		claimed && pcfg == FPPD_PULSE_DIR && rise_o && sync2_q[1]
		|=> tot_r_q == $past(tot_r_q) + 32'h00000001 && tot_f_q == $past(tot_f_q))
		else $error("pulse with reverse level miscounted");
	AST_EVEN_CLAIMED: assert property (@(posedge pclk) disable iff (!presetn)
		claimed && pcfg == FPPD_PULSE_DIR && !rise_o |=> $stable(tot_r_q))
		else $error("claimed even pin counted as pulse");
	AST_FR_EVEN: assert property (@(posedge pclk) disable iff (!presetn)
		claimed && pcfg == FPPD_FWD_REV && rise_e |=> tot_r_q != $past(tot_r_q))
		else $error("reverse line pulse lost");
	AST_QUAD_FWD: assert property (@(posedge pclk) disable iff (!presetn)
		claimed && pcfg == FPPD_QUAD && se_q && smp_q == 2'h0 && sync2_q == 2'h2
		|=> tot_f_q == $past(tot_f_q) + 32'h00000001)
		else $error("quadrature forward step lost");
	AST_QUAD_REV: assert property (@(posedge pclk) disable iff (!presetn)
		claimed && pcfg == FPPD_QUAD && se_q && smp_q == 2'h0 && sync2_q == 2'h1
		|=> tot_r_q == $past(tot_r_q) + 32'h00000001)
		else $error("quadrature reverse step lost");
	AST_QUAD_JUMP: assert property (@(posedge pclk) disable iff (!presetn)
		claimed && pcfg == FPPD_QUAD && se_q && (smp_q ^ sync2_q) == 2'h3
		|=> $stable(tot_f_q) && $stable(tot_r_q))
		else $error("illegal quadrature jump counted");
	AST_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
		log_q |=> per_f_q == {31'h0, $past(inc_f)})
		else $error("period counter not restarted");
	AST_NET_DP: assert property (@(posedge pclk) disable iff (!presetn)
		s_boundary ##0 (claimed && !indep) |=> dp_strobe_q
		&& dp_odd_q == $past(per_f_q) - $past(per_r_q) && dp_even_q == 32'h00000000)
		else $error("net datapoint wrong");
	AST_INDEP_DP: assert property (@(posedge pclk) disable iff (!presetn)
		log_q && indep |=> dp_odd_q == $past(per_f_q) && dp_even_q == $past(per_r_q))
		else $error("independent datapoints wrong");
endmodule
